// File: shared/e3fo_pkg.sv
// Constants shared by the E3 G.832 frame overhead block
package e3fo_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Register port
  localparam logic [7:0] ADDR_MODE          = 8'h00;
  localparam logic [7:0] MODE_RESET_VAL     = 8'h00;
  localparam int         MODE_LINE_BIT      = 6;
  localparam int         MODE_SOFT_RST_BIT  = 4;
  localparam int         MODE_FMT_BIT       = 2;

  //////////////////////////////////////////////////////////////////////////
  // Frame geometry
  localparam int         FRAME_ROWS         = 9;
  localparam int         FRAME_COLS         = 60;
  localparam int         SHORT_COLS         = 59;
  localparam int         FIRST_SHORT_ROW    = 6;
  localparam int         FRAME_OCTETS       = 537;
  localparam int         OH_OCTETS          = 7;
  localparam int         PAY_OCTETS         = FRAME_OCTETS - OH_OCTETS;

  // Overhead positions, all in column zero except the second alignment byte
  localparam logic [3:0] ROW_FA             = 4'h0;
  localparam logic [3:0] ROW_EM             = 4'h1;
  localparam logic [3:0] ROW_TR             = 4'h2;
  localparam logic [3:0] ROW_MA             = 4'h3;
  localparam logic [3:0] ROW_NR             = 4'h4;
  localparam logic [3:0] ROW_GC             = 4'h5;
  localparam logic [5:0] COL_FA2            = 6'h01;

  //////////////////////////////////////////////////////////////////////////
  // Overhead values and fields
  localparam logic [7:0] FA1_VAL            = 8'hf6;
  localparam logic [7:0] FA2_VAL            = 8'h28;
  localparam logic [7:0] NR_IDLE            = 8'h00;
  localparam logic [7:0] GC_IDLE            = 8'h00;
  localparam int         MA_FERF_BIT        = 7;
  localparam int         MA_FEBE_BIT        = 6;
  localparam int         TTB_LEN            = 16;
  localparam int         TTB_CHARS          = 15;
  localparam logic [6:0] CRC7_POLY          = 7'h09;
  localparam int         OOF_BAD_FRAMES     = 2;

  //////////////////////////////////////////////////////////////////////////
  // Rates
  localparam int         FRAME_HZ           = 8000;
  localparam int         LINE_KBPS          = 34368;
  localparam int         CLK_KHZ            = 40000;
  localparam int         OCT_KHZ            = LINE_KBPS / 8;
  localparam logic [15:0] OCT_STEP          = 16'(OCT_KHZ);
  localparam logic [15:0] OCT_WRAP          = 16'(CLK_KHZ);

endpackage : e3fo_pkg

// File: verilog/e3fo_crc7.sv
// One-octet step of the trail trace CRC-7, most significant bit first
`timescale 1ns/10ps
module e3fo_crc7
  import e3fo_pkg::*;
(
  // Running remainder and next octet
  input  wire logic [6:0] i_crc,
  input  wire logic [7:0] i_byte,
  // Updated remainder
  output logic      [6:0] o_crc
);

  logic [6:0] c;
  logic       fb;

  always_comb begin
    c  = i_crc;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      fb = c[6] ^ i_byte[i];
      c  = {c[5:0], 1'b0} ^ (fb ? CRC7_POLY : 7'h00);
    end
    o_crc = c;
  end

endmodule : e3fo_crc7

// File: verilog/e3fo_frame_overhead.sv
// E3 G.832 frame generation, alignment, BIP-8, FEBE/FERF and trail trace
//
// Operation
// - G.832 mode runs when mode bits 6 and 4 are 0 and bit 2 is 1.
// - Octets form 9 rows of 60 columns; last three rows hold 59.
// - Frames repeat 8000 times a second, 34.368 Mbps on the line.
// - Overhead octets are FA1, FA2, EM, TR, MA, NR and GC.
// - FA1 is 0xF6, FA2 is 0x28; receiver hunts both for alignment.
// - Transmit BIP-8 over all 537 octets goes into next frame's EM.
// - BIP-8 bit n is even parity over bit n of every octet.
// - Receiver checks its own BIP-8 against next frame's EM byte.
// - EM mismatch marks frame errored; outbound FEBE bit sent as 1.
// - EM match sends outbound FEBE bit as 0 in MA.
// - Trail trace byte repeats a 16-byte access point identifier.
// - First trail trace byte has its top bit set as start marker.
// - Start byte low seven bits carry CRC-7 of previous 16 bytes.
// - Following 15 trail trace bytes carry ASCII E.164 characters.
// - FEBE occupies bit 6 of the MA byte.
// - FERF (MA bit 7) is 1 during LOS, OOF or AIS, else 0.
`timescale 1ns/10ps
module e3fo_frame_overhead
  import e3fo_pkg::*;
#(
  parameter logic [2:0] PAYLOAD_TYPE  = 3'h1,
  parameter logic       TIMING_MARKER = 1'b0
)
(
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_arst_n,
  // Microprocessor register port
  input  wire logic                   i_reg_wr,
  input  wire logic                   i_reg_rd,
  input  wire logic [7:0]             i_reg_addr,
  input  wire logic [7:0]             i_reg_wdata,
  output logic      [7:0]             o_reg_rdata,
  // Transmit payload and trail trace characters
  input  wire logic [7:0]             i_tx_pay_data,
  output logic                        o_tx_pay_take,
  input  wire logic [8*TTB_CHARS-1:0] i_ttb_chars,
  // Transmit line octets
  output logic      [7:0]             o_tx_data,
  output logic                        o_tx_strobe,
  output logic                        o_tx_sof,
  // Receive line octets and defect pins
  input  wire logic [7:0]             i_rx_data,
  input  wire logic                   i_rx_strobe,
  input  wire logic                   i_rx_los,
  input  wire logic                   i_rx_ais,
  // Receive results
  output logic      [7:0]             o_rx_pay_data,
  output logic                        o_rx_pay_valid,
  output logic                        o_rx_in_frame,
  output logic                        o_rx_bip_err,
  output logic                        o_tx_ferf
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef enum logic [1:0] {RX_SEARCH, RX_FA2, RX_LOCK} e3fo_rx_st_t;

  typedef struct packed {
    logic [7:0]  mode;
    logic [7:0]  rdata;
    logic [15:0] acc;
    logic [3:0]  t_row;
    logic [5:0]  t_col;
    logic [7:0]  t_bip;
    logic [7:0]  t_em;
    logic [3:0]  ttb_idx;
    logic [6:0]  t_crc;
    logic [6:0]  t_crc_last;
    logic [7:0]  tx_data;
    logic        tx_strobe;
    logic        tx_sof;
    logic        pay_take;
    logic [2:0]  los_q;
    logic [2:0]  ais_q;
    logic        los_s;
    logic        ais_s;
    e3fo_rx_st_t rx_st;
    logic [3:0]  r_row;
    logic [5:0]  r_col;
    logic [7:0]  r_bip;
    logic [7:0]  r_em_ref;
    logic        r_em_ok;
    logic        r_fa_bad;
    logic [1:0]  bad_cnt;
    logic        febe;
    logic        ferf;
    logic [7:0]  rx_pay;
    logic        rx_pay_v;
    logic        bip_err;
    logic        in_frame;
  } e3fo_st_t;

  e3fo_st_t st_reg;
  e3fo_st_t st_next;

  logic [6:0] crc_in;
  logic [7:0] crc_byte;
  logic [6:0] crc_out;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic last_col(input logic [3:0] row,
                                    input logic [5:0] col);
    if (row >= 4'(FIRST_SHORT_ROW))
      last_col = (col == 6'(SHORT_COLS - 1));
    else
      last_col = (col == 6'(FRAME_COLS - 1));
  endfunction : last_col

  function automatic logic is_oh(input logic [3:0] row,
                                 input logic [5:0] col);
    is_oh = ((col == 6'h00) && (row <= ROW_GC)) ||
            ((row == ROW_FA) && (col == COL_FA2));
  endfunction : is_oh

  e3fo_crc7 u_crc7 (
    .i_crc  (crc_in),
    .i_byte (crc_byte),
    .o_crc  (crc_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic        g832;
    logic        oct_en;
    logic [15:0] acc_sum;
    logic [7:0]  tb;
    logic [7:0]  ma;
    logic [7:0]  trail_trace_byte;
    logic [7:0]  rsum;
    logic        frame_bad;
    logic        t_last;
    logic        r_last;

    st_next   = st_reg;
    g832      = 1'b0;
    oct_en    = 1'b0;
    acc_sum   = 16'h0000;
    tb        = 8'h00;
    ma        = 8'h00;
    trail_trace_byte       = 8'h00;
    rsum      = 8'h00;
    frame_bad = 1'b0;
    t_last    = 1'b0;
    r_last    = 1'b0;
    crc_in    = 7'h00;
    crc_byte  = 8'h00;

    st_next.tx_strobe = 1'b0;
    st_next.tx_sof    = 1'b0;
    st_next.pay_take  = 1'b0;
    st_next.rx_pay_v  = 1'b0;
    st_next.bip_err   = 1'b0;

    // Register port
    if (i_reg_wr && (i_reg_addr == ADDR_MODE)) begin
      st_next.mode = i_reg_wdata;
    end
    if (i_reg_rd) begin
      st_next.rdata = (i_reg_addr == ADDR_MODE) ? st_reg.mode : 8'h00;
    end

    g832 = !st_reg.mode[MODE_LINE_BIT] && st_reg.mode[MODE_FMT_BIT] &&
           !st_reg.mode[MODE_SOFT_RST_BIT];

    // Defect pins, three-stage synchronisers
    st_next.los_q = {st_reg.los_q[1:0], i_rx_los};
    st_next.ais_q = {st_reg.ais_q[1:0], i_rx_ais};
    if (st_reg.los_q[1] == st_reg.los_q[2]) begin
      st_next.los_s = st_reg.los_q[2];
    end
    if (st_reg.ais_q[1] == st_reg.ais_q[2]) begin
      st_next.ais_s = st_reg.ais_q[2];
    end
    st_next.ferf = st_reg.los_s || st_reg.ais_s ||
                   (st_reg.rx_st != RX_LOCK);

    // Octet rate divider, fractional
    acc_sum = st_reg.acc + OCT_STEP;
    if (acc_sum >= OCT_WRAP) begin
      oct_en      = 1'b1;
      st_next.acc = acc_sum - OCT_WRAP;
    end else begin
      st_next.acc = acc_sum;
    end

    //////////////////////////////////////////////////////////////////////////
    // Transmit
    ma = {st_reg.ferf, st_reg.febe, PAYLOAD_TYPE, 2'b00, TIMING_MARKER};
    if (st_reg.ttb_idx == 4'h0) begin
      trail_trace_byte = {1'b1, st_reg.t_crc_last};
    end else begin
      trail_trace_byte = i_ttb_chars[8*(int'(st_reg.ttb_idx)-1) +: 8];
    end

    if (!g832) begin
      st_next.t_row   = 4'h0;
      st_next.t_col   = 6'h00;
      st_next.t_bip   = 8'h00;
      st_next.ttb_idx = 4'h0;
      st_next.t_crc   = 7'h00;
    end else if (oct_en) begin
      if (st_reg.t_col == 6'h00) begin
        case (st_reg.t_row)
          ROW_FA:  tb = FA1_VAL;
          ROW_EM:  tb = st_reg.t_em;
          ROW_TR:  tb = trail_trace_byte;
          ROW_MA:  tb = ma;
          ROW_NR:  tb = NR_IDLE;
          ROW_GC:  tb = GC_IDLE;
          default: tb = i_tx_pay_data;
        endcase
      end else if ((st_reg.t_row == ROW_FA) && (st_reg.t_col == COL_FA2)) begin
        tb = FA2_VAL;
      end else begin
        tb = i_tx_pay_data;
      end
      st_next.pay_take  = !is_oh(st_reg.t_row, st_reg.t_col);
      st_next.tx_data   = tb;
      st_next.tx_strobe = 1'b1;
      st_next.tx_sof    = (st_reg.t_row == ROW_FA) && (st_reg.t_col == 6'h00);

      // Trail trace CRC over the sixteen bytes as sent
      if ((st_reg.t_col == 6'h00) && (st_reg.t_row == ROW_TR)) begin
        crc_in          = (st_reg.ttb_idx == 4'h0) ? 7'h00 : st_reg.t_crc;
        crc_byte        = tb;
        st_next.t_crc   = crc_out;
        st_next.ttb_idx = st_reg.ttb_idx + 4'h1;
        if (st_reg.ttb_idx == 4'(TTB_LEN - 1)) begin
          st_next.t_crc_last = crc_out;
        end
      end

      // BIP-8 and position
      t_last = (st_reg.t_row == 4'(FRAME_ROWS - 1)) &&
               last_col(st_reg.t_row, st_reg.t_col);
      if (t_last) begin
        st_next.t_em  = st_reg.t_bip ^ tb;
        st_next.t_bip = 8'h00;
        st_next.t_row = 4'h0;
        st_next.t_col = 6'h00;
      end else begin
        st_next.t_bip = st_reg.t_bip ^ tb;
        if (last_col(st_reg.t_row, st_reg.t_col)) begin
          st_next.t_row = st_reg.t_row + 4'h1;
          st_next.t_col = 6'h00;
        end else begin
          st_next.t_col = st_reg.t_col + 6'h01;
        end
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // Receive
    if (!g832) begin
      st_next.rx_st = RX_SEARCH;
    end else if (i_rx_strobe) begin
      case (st_reg.rx_st)
        RX_SEARCH: begin
          if (i_rx_data == FA1_VAL) begin
            st_next.rx_st = RX_FA2;
          end
        end
        RX_FA2: begin
          if (i_rx_data == FA2_VAL) begin
            st_next.rx_st    = RX_LOCK;
            st_next.r_row    = ROW_FA;
            st_next.r_col    = COL_FA2 + 6'h01;
            st_next.r_bip    = FA1_VAL ^ FA2_VAL;
            st_next.r_em_ok  = 1'b0;
            st_next.r_fa_bad = 1'b0;
            st_next.bad_cnt  = 2'h0;
          end else if (i_rx_data != FA1_VAL) begin
            st_next.rx_st = RX_SEARCH;
          end
        end
        RX_LOCK: begin
          rsum = st_reg.r_bip ^ i_rx_data;
          if ((st_reg.r_row == ROW_FA) &&
              (((st_reg.r_col == 6'h00) && (i_rx_data != FA1_VAL)) ||
               ((st_reg.r_col == COL_FA2) && (i_rx_data != FA2_VAL)))) begin
            st_next.r_fa_bad = 1'b1;
          end
          if ((st_reg.r_row == ROW_EM) && (st_reg.r_col == 6'h00) &&
              st_reg.r_em_ok) begin
            st_next.febe    = (i_rx_data != st_reg.r_em_ref);
            st_next.bip_err = (i_rx_data != st_reg.r_em_ref);
          end
          if (!is_oh(st_reg.r_row, st_reg.r_col)) begin
            st_next.rx_pay   = i_rx_data;
            st_next.rx_pay_v = 1'b1;
          end
          r_last = (st_reg.r_row == 4'(FRAME_ROWS - 1)) &&
                   last_col(st_reg.r_row, st_reg.r_col);
          if (r_last) begin
            st_next.r_em_ref = rsum;
            st_next.r_em_ok  = 1'b1;
            st_next.r_bip    = 8'h00;
            st_next.r_row    = 4'h0;
            st_next.r_col    = 6'h00;
            st_next.r_fa_bad = 1'b0;
            frame_bad        = st_reg.r_fa_bad;
            if (frame_bad) begin
              st_next.bad_cnt = st_reg.bad_cnt + 2'h1;
              if (st_reg.bad_cnt == 2'(OOF_BAD_FRAMES - 1)) begin
                st_next.rx_st = RX_SEARCH;
              end
            end else begin
              st_next.bad_cnt = 2'h0;
            end
          end else begin
            st_next.r_bip = rsum;
            if (last_col(st_reg.r_row, st_reg.r_col)) begin
              st_next.r_row = st_reg.r_row + 4'h1;
              st_next.r_col = 6'h00;
            end else begin
              st_next.r_col = st_reg.r_col + 6'h01;
            end
          end
        end
        default: st_next.rx_st = RX_SEARCH;
      endcase
    end
    st_next.in_frame = (st_next.rx_st == RX_LOCK);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg      <= '0;
      st_reg.mode <= MODE_RESET_VAL;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_reg_rdata    = st_reg.rdata;
  assign o_tx_pay_take  = st_reg.pay_take;
  assign o_tx_data      = st_reg.tx_data;
  assign o_tx_strobe    = st_reg.tx_strobe;
  assign o_tx_sof       = st_reg.tx_sof;
  assign o_rx_pay_data  = st_reg.rx_pay;
  assign o_rx_pay_valid = st_reg.rx_pay_v;
  assign o_rx_in_frame  = st_reg.in_frame;
  assign o_rx_bip_err   = st_reg.bip_err;
  assign o_tx_ferf      = st_reg.ferf;

endmodule : e3fo_frame_overhead

// File: tb/e3fo_frame_overhead_checker.sv
// Port assertions for the E3 frame overhead block
`timescale 1ns/10ps
module e3fo_frame_overhead_checker
  import e3fo_pkg::*;
(
  // Clock, reset and register port
  input wire logic       i_clk,
  input wire logic       i_arst_n,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] o_reg_rdata,
  // Line side
  input wire logic       i_rx_strobe,
  input wire logic       i_rx_los,
  input wire logic [7:0] o_tx_data,
  input wire logic       o_tx_strobe,
  input wire logic       o_tx_sof,
  input wire logic       o_tx_pay_take,
  input wire logic       o_rx_pay_valid,
  input wire logic       o_rx_in_frame,
  input wire logic       o_rx_bip_err,
  input wire logic       o_tx_ferf
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  ////////////////////////////////////////////////////////////
  // Octets since the last frame start
  logic [9:0] oct_reg;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n)
      oct_reg <= 10'h000;
    else if (i_reg_wr)
      oct_reg <= 10'h000;
    else if (o_tx_strobe)
      oct_reg <= o_tx_sof ? 10'h001 : oct_reg + 10'h001;
  end
  sequence s_fa1;
    o_tx_strobe && o_tx_data == FA1_VAL;
  endsequence
  sequence s_fa2;
    o_tx_strobe && o_tx_data == FA2_VAL;
  endsequence
  ////////////////////////////////////////////////////////////
  a_align_bytes: assert property (
    o_tx_sof |-> s_fa1 ##[9:10] s_fa2) else $error("alignment bytes");
  a_frame_length: assert property (
    o_tx_sof && oct_reg != 10'h000 |-> oct_reg == 10'd537)
    else $error("frame length");
  a_octet_spacing: assert property (
    o_tx_strobe |=> (!o_tx_strobe)[*8]) else $error("octet spacing");
  a_payload_take: assert property (
    o_tx_pay_take |-> o_tx_strobe && !o_tx_sof) else $error("take");
  a_ferf_los: assert property (
    i_rx_los[*6] |=> o_tx_ferf) else $error("ferf on los");
  a_ferf_unlock: assert property (
    (!o_rx_in_frame)[*3] |-> o_tx_ferf) else $error("ferf unlocked");
  a_bip_cause: assert property (
    o_rx_bip_err |-> ($past(i_rx_strobe) && o_rx_in_frame) ##1 !o_rx_bip_err)
    else $error("bip error pulse");
  a_pay_cause: assert property (
    o_rx_pay_valid |-> $past(i_rx_strobe) && !o_rx_bip_err)
    else $error("payload valid");
  a_unmapped_read: assert property (
    $past(i_reg_rd) && $past(i_reg_addr) != ADDR_MODE |-> o_reg_rdata == 8'h00)
    else $error("unmapped read");
  a_rdata_hold: assert property (
    !$past(i_reg_rd) |-> $stable(o_reg_rdata)) else $error("read hold");
endmodule : e3fo_frame_overhead_checker

bind e3fo_frame_overhead e3fo_frame_overhead_checker i_chk (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .o_reg_rdata(o_reg_rdata),
  .i_rx_strobe(i_rx_strobe), .i_rx_los(i_rx_los), .o_tx_data(o_tx_data),
  .o_tx_strobe(o_tx_strobe), .o_tx_sof(o_tx_sof),
  .o_tx_pay_take(o_tx_pay_take), .o_rx_pay_valid(o_rx_pay_valid),
  .o_rx_in_frame(o_rx_in_frame), .o_rx_bip_err(o_rx_bip_err),
  .o_tx_ferf(o_tx_ferf));

// File: tb/e3fo_line_model.sv
// Remote terminal sending E3 frames to the receiver
`timescale 1ns/10ps
module e3fo_line_model
  import e3fo_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_run,
  input  wire logic       i_em_bad,
  output logic      [7:0] o_rx_data,
  output logic            o_rx_strobe
);
  logic [3:0] gap_reg;
  logic [9:0] pos_reg;
  logic [7:0] acc_reg;
  logic [7:0] em_reg;
  logic [7:0] oct;
  always_comb begin
    if (pos_reg == 10'd0)
      oct = FA1_VAL;
    else if (pos_reg == 10'd1)
      oct = FA2_VAL;
    else if (pos_reg == 10'd60)
      oct = em_reg ^ {7'h00, i_em_bad};
    else
      oct = pos_reg[7:0] ^ 8'h5a;
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gap_reg     <= 4'h0;
      pos_reg     <= 10'h000;
      acc_reg     <= 8'h00;
      em_reg      <= 8'h00;
      o_rx_data   <= 8'h00;
      o_rx_strobe <= 1'b0;
    end else if (i_run && gap_reg == 4'h9) begin
      gap_reg     <= 4'h0;
      o_rx_strobe <= 1'b1;
      o_rx_data   <= oct;
      if (pos_reg == 10'd536) begin
        pos_reg <= 10'h000;
        em_reg  <= acc_reg ^ oct;
        acc_reg <= 8'h00;
      end else begin
        pos_reg <= pos_reg + 10'h001;
        acc_reg <= acc_reg ^ oct;
      end
    end else begin
      gap_reg     <= (gap_reg == 4'h9) ? gap_reg : gap_reg + 4'h1;
      o_rx_strobe <= 1'b0;
      o_rx_data   <= ~o_rx_data;
    end
  end
endmodule : e3fo_line_model

// File: tb/e3fo_frame_overhead_tb.sv
// Self-checking bench for the E3 frame overhead block
`timescale 1ns/10ps
`define CHK(nm, e, a) \
  begin \
    checks_done++; \
    if ((a) !== (e)) begin \
      fail_count++; \
      $display("mismatch %s expected %h seen %h", nm, e, a); \
    end \
  end
module e3fo_frame_overhead_tb
  import e3fo_pkg::*;
;
  logic                   clk;
  logic                   arst_n;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [7:0]             reg_addr;
  logic [7:0]             reg_wdata;
  logic [7:0]             reg_rdata;
  logic [7:0]             tx_pay_data;
  logic                   tx_pay_take;
  logic [8*TTB_CHARS-1:0] ttb_chars;
  logic [7:0]             tx_data;
  logic                   tx_strobe;
  logic                   tx_sof;
  logic [7:0]             rx_data;
  logic                   rx_strobe;
  logic                   rx_los;
  logic                   rx_ais;
  logic [7:0]             rx_pay;
  logic                   rx_pay_v;
  logic                   in_frame;
  logic                   bip_err;
  logic                   tx_ferf;
  logic                   run;
  logic                   em_bad;
  int                     fail_count = 0;
  int                     checks_done = 0;
  e3fo_frame_overhead i_dut (
    .i_clk(clk), .i_arst_n(arst_n), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
    .i_tx_pay_data(tx_pay_data), .o_tx_pay_take(tx_pay_take),
    .i_ttb_chars(ttb_chars), .o_tx_data(tx_data), .o_tx_strobe(tx_strobe),
    .o_tx_sof(tx_sof), .i_rx_data(rx_data), .i_rx_strobe(rx_strobe),
    .i_rx_los(rx_los), .i_rx_ais(rx_ais), .o_rx_pay_data(rx_pay),
    .o_rx_pay_valid(rx_pay_v), .o_rx_in_frame(in_frame),
    .o_rx_bip_err(bip_err),
    .o_tx_ferf(tx_ferf));
  e3fo_line_model i_line (.i_clk(clk), .i_arst_n(arst_n), .i_run(run),
    .i_em_bad(em_bad), .o_rx_data(rx_data), .o_rx_strobe(rx_strobe));
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (tx_pay_take === 1'b1)
      tx_pay_data <= tx_pay_data + 8'h01;
  end
  ////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    tick();
    d = reg_rdata;
  endtask : rd
  task automatic get_oct(output logic [7:0] d, output logic s);
    int n;
    n = 0;
    do begin
      tick();
      n++;
    end while (tx_strobe !== 1'b1 && n < 40);
    d = tx_data;
    s = tx_sof;
  endtask : get_oct
  task automatic wait_ma(output logic [7:0] m);
    logic s;
    s = 1'b0;
    for (int n = 0; n < 600 && s !== 1'b1; n++) get_oct(m, s);
    repeat (180) get_oct(m, s);
  endtask : wait_ma
  ////////////////////////////////////////////////////////////
  task automatic t_reg();
    logic [7:0] d;
    wr(8'h33, 8'hff);
    rd(ADDR_MODE, d);
    `CHK("mode reset", MODE_RESET_VAL, d)
    rd(8'h5a, d);
    `CHK("unmapped", 8'h00, d)
    wr(ADDR_MODE, 8'h04);
    rd(ADDR_MODE, d);
    `CHK("mode", 8'h04, d)
  endtask : t_reg
  task automatic t_tx();
    logic [7:0] f [0:1610];
    logic [7:0] x;
    logic       s;
    int         sofs;
    int         lastp;
    int         b;
    int         p;
    sofs = 0;
    lastp = -1;
    s = 1'b0;
    for (int i = 0; i < 600 && s !== 1'b1; i++) get_oct(f[0], s);
    for (int i = 1; i < 1611; i++) begin
      get_oct(f[i], s);
      sofs += int'(s);
    end
    `CHK("sof count", 2, sofs)
    `CHK("em first", 8'h00, f[60])
    `CHK("tr start", 8'h80, f[120])
    `CHK("tr char", ttb_chars[7:0], f[657])
    `CHK("tr char", ttb_chars[15:8], f[1194])
    for (int k = 0; k < 3; k++) begin
      b = 537 * k;
      x = 8'h00;
      for (int i = 0; i < 537; i++) x ^= f[b + i];
      `CHK("fa1", FA1_VAL, f[b])
      `CHK("fa2", FA2_VAL, f[b + 1])
      `CHK("ma", 8'h88, f[b + 180])
      `CHK("nr", NR_IDLE, f[b + 240])
      `CHK("gc", GC_IDLE, f[b + 300])
      if (k < 2) `CHK("em", x, f[b + 597])
    end
    for (int i = 0; i < 1611; i++) begin
      p = i % 537;
      if (p > 1 && !(p <= 300 && p % 60 == 0)) begin
        if (lastp >= 0) `CHK("payload", f[lastp] + 8'h01, f[i])
        lastp = i;
      end
    end
  endtask : t_tx
  task automatic t_rx();
    logic [7:0] m;
    logic [7:0] sent;
    int         errs;
    int         pays;
    errs = 0;
    pays = 0;
    sent = 8'h00;
    @(posedge clk) run <= 1'b1;
    for (int n = 0; n < 12000 && in_frame !== 1'b1; n++) tick();
    `CHK("lock", 1'b1, in_frame)
    for (int n = 0; n < 7000; n++) begin
      tick();
      errs += int'(bip_err !== 1'b0);
      if (n < 5370 && rx_pay_v === 1'b1) pays++;
      if (rx_pay_v === 1'b1) `CHK("rx payload", sent, rx_pay)
      if (rx_strobe === 1'b1) sent = rx_data;
    end
    `CHK("bip quiet", 0, errs)
    `CHK("rx payload count", 530, pays)
    wait_ma(m);
    `CHK("ma flags", 2'b00, m[7:6])
    @(posedge clk) em_bad <= 1'b1;
    for (int n = 0; n < 6000 && bip_err !== 1'b1; n++) tick();
    `CHK("bip error", 1'b1, bip_err)
    wait_ma(m);
    `CHK("febe set", 1'b1, m[6])
    @(posedge clk) em_bad <= 1'b0;
    repeat (5500) tick();
    wait_ma(m);
    `CHK("febe clear", 1'b0, m[6])
  endtask : t_rx
  task automatic t_ferf();
    logic [7:0] m;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) {rx_ais, rx_los} <= (k == 1) ? 2'b10 : 2'b01;
      repeat (10) tick();
      `CHK("ferf on", 1'b1, tx_ferf)
      wait_ma(m);
      `CHK("ma ferf", 1'b1, m[7])
      @(posedge clk) {rx_ais, rx_los} <= 2'b00;
      repeat (10) tick();
      `CHK("ferf off", 1'b0, tx_ferf)
    end
  endtask : t_ferf
  task automatic t_refuse();
    logic [7:0] v [3] = '{8'h44, 8'h14, 8'h00};
    logic [7:0] d;
    logic       s;
    int         cnt;
    foreach (v[k]) begin
      s = 1'b1;
      while (s !== 1'b0) get_oct(d, s);
      wr(ADDR_MODE, v[k]);
      cnt = 0;
      repeat (40) begin
        tick();
        cnt += int'(tx_strobe !== 1'b0);
      end
      `CHK("idle", 0, cnt)
      rd(ADDR_MODE, d);
      `CHK("mode", v[k], d)
    end
    wr(ADDR_MODE, 8'h04);
    s = 1'b0;
    for (int n = 0; n < 40 && s !== 1'b1; n++) get_oct(d, s);
    `CHK("restart", FA1_VAL, d)
  endtask : t_refuse
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (95000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
  initial begin
    {clk, arst_n, reg_wr, reg_rd, rx_los, rx_ais, run, em_bad} = 8'h00;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    tx_pay_data = 8'h00;
    for (int k = 0; k < TTB_CHARS; k++) ttb_chars[8*k +: 8] = 8'h41 + 8'(k);
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    t_reg();
    t_tx();
    t_rx();
    t_ferf();
    t_refuse();
    give_verdict();
  end
endmodule : e3fo_frame_overhead_tb
